//--- rtl/tim_consts.vh
// Constants for the host interface mode controller.
`ifndef TIM_CONSTS_VH
`define TIM_CONSTS_VH
`define TIM_BYTE_FRAME_END 8'hc0
`define TIM_BYTE_QUIT_LO 8'h71
`define TIM_BYTE_QUIT_UP 8'h51
`define TIM_BYTE_RAW_EXIT 8'hff
`define TIM_MODE_TERMINAL 2'h0
`define TIM_MODE_HOST 2'h1
`define TIM_MODE_RAW 2'h2
`define TIM_MODE_DEFAULT 2'h0
`define TIM_ESC_IDLE 2'h0
`define TIM_ESC_GOT_FEND 2'h1
`define TIM_ESC_GOT_EXIT 2'h2
`define TIM_AUX_OFF 2'h0
`define TIM_AUX_POSITION 2'h1
`define TIM_AUX_NODE 2'h2
`define TIM_PORT_HF 1'b0
`define TIM_PORT_VHF 1'b1
`endif

//--- rtl/tim_sync2.v
// Two-stage synchroniser for signals arriving from pins.
`timescale 1ns/100ps
`default_nettype none
module tim_sync2 #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  // The first stage is read only by the second stage.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;
endmodule // tim_sync2
`default_nettype wire

//--- rtl/tim_host_if.v
// Host interface mode controller: mode state, escape detection, flow control, port routing.
// Notes on behaviour
// - Framed host mode exchanges typed frames; they pass as a stream to the frame engine.
// - Framed host mode uses only RTS/CTS handshake, never software flow control.
// - In host mode, frame-end, q or Q, frame-end leaves that mode.
// - Leaving host mode selects terminal mode and sends the sign-on greeting.
// - Still in host mode when a terminal connects: send current-status, not greeting.
// - Choosing raw mode takes effect only after a reset command or power cycle; here power-on reset loads terminal mode, so only the reset command does.
// - Raw mode persists over ordinary resets until exit code or hard reset; here a mode write selecting host also leaves it at once.
// - Raw mode forwards every radio frame to the host untouched, no relaying.
// - Raw mode converts between synchronous radio and asynchronous host framing.
// - In raw mode the device still times radio channel access itself.
// - Nonzero position-input rate makes the auxiliary port a position sentence input.
// - Nonzero node-link rate makes the auxiliary port a node interconnection.
// - Terminal mode allows only one radio communication mode at a time; the code keeps a packet grant for one cycle after non-packet goes active.
// - A non-packet HF mode keeps the VHF port open to remote stations.
// - Host mode allows packet traffic together with one non-packet HF mode.
// - Keyed Morse output is driven for radio port 0 (HF) only.
// - In raw mode, frame-end, 255, frame-end returns to terminal mode.
// - Host link is 8 data bits, no parity, one stop bit, 300 to 38400 baud.
// - CTS tells the host whether more serial data can be accepted.
`timescale 1ns/100ps
`default_nettype none
`include "tim_consts.vh"
module tim_host_if #(
  parameter DATA_WIDTH = 8,
  parameter RATE_WIDTH = 16
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire i_host_rx_valid,
  input wire [DATA_WIDTH-1:0] i_host_rx_data,
  input wire i_rx_space,
  input wire i_host_rts,
  input wire i_terminal_connect,
  input wire i_reset_cmd,
  input wire i_hard_reset,
  input wire i_mode_select_wr,
  input wire [1:0] i_interface_mode_select,
  input wire [RATE_WIDTH-1:0] i_position_input_rate,
  input wire [RATE_WIDTH-1:0] i_node_link_rate,
  input wire i_radio_frame_valid,
  input wire i_radio_frame_port,
  input wire i_radio_nonpacket_req,
  input wire i_radio_nonpacket_port,
  input wire i_packet_req,
  input wire i_morse_key,
  input wire i_morse_port,
  output reg [1:0] o_mode,
  output reg [1:0] o_stored_mode,
  output reg o_host_cts,
  output reg o_soft_flow_enable,
  output reg o_frame_rx_valid,
  output reg [DATA_WIDTH-1:0] o_frame_rx_data,
  output reg o_cmd_rx_valid,
  output reg [DATA_WIDTH-1:0] o_cmd_rx_data,
  output reg o_send_greeting,
  output reg o_send_status,
  output reg o_raw_forward,
  output reg o_raw_convert,
  output reg o_local_routing_enable,
  output reg o_channel_access_local,
  output reg [1:0] o_aux_route,
  output reg [RATE_WIDTH-1:0] o_aux_rate,
  output reg o_nonpacket_active,
  output reg o_packet_grant,
  output reg o_vhf_remote_open,
  output reg o_morse_key_out
);
  // Pin-side inputs pass two flip-flops before use.
  wire rts_sync;
  wire connect_sync;
  reg connect_prev;
  reg [1:0] esc_state;
  reg [1:0] next_esc_state;
  reg esc_exit;
  reg esc_swallow;
  reg [1:0] pending_mode;

  tim_sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_host_rts, i_terminal_connect}),
    .o_sync({rts_sync, connect_sync})
  );

  // Escape recogniser: opener, exit byte of the current mode, closer.
  always @*
  begin
    next_esc_state = esc_state;
    esc_exit = 1'b0;
    esc_swallow = 1'b0;
    if (i_host_rx_valid && (o_mode != `TIM_MODE_TERMINAL))
    begin
      case (esc_state)
        `TIM_ESC_IDLE:
        begin
          if (i_host_rx_data == `TIM_BYTE_FRAME_END)
            next_esc_state = `TIM_ESC_GOT_FEND;
        end
        `TIM_ESC_GOT_FEND:
        begin
          if ((o_mode == `TIM_MODE_HOST) &&
              ((i_host_rx_data == `TIM_BYTE_QUIT_LO) || (i_host_rx_data == `TIM_BYTE_QUIT_UP)))
            next_esc_state = `TIM_ESC_GOT_EXIT;
          else if ((o_mode == `TIM_MODE_RAW) && (i_host_rx_data == `TIM_BYTE_RAW_EXIT))
            next_esc_state = `TIM_ESC_GOT_EXIT;
          else if (i_host_rx_data == `TIM_BYTE_FRAME_END)
            next_esc_state = `TIM_ESC_GOT_FEND;
          else
            next_esc_state = `TIM_ESC_IDLE;
        end
        `TIM_ESC_GOT_EXIT:
        begin
          if (i_host_rx_data == `TIM_BYTE_FRAME_END)
          begin
            esc_exit = 1'b1;
            esc_swallow = 1'b1;
          end
          next_esc_state = `TIM_ESC_IDLE;
        end
        default:
          next_esc_state = `TIM_ESC_IDLE;
      endcase
    end
  end

  // Mode register. A reset command loads the stored selection, so a raw
  // selection waits for it, and a stored raw mode survives it.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_mode <= `TIM_MODE_DEFAULT;
      o_stored_mode <= `TIM_MODE_DEFAULT;
      pending_mode <= `TIM_MODE_DEFAULT;
      esc_state <= `TIM_ESC_IDLE;
      o_send_greeting <= 1'b0;
      o_send_status <= 1'b0;
      connect_prev <= 1'b0;
    end
    else
    begin
      connect_prev <= connect_sync;
      o_send_greeting <= 1'b0;
      o_send_status <= 1'b0;
      esc_state <= next_esc_state;
      if (i_hard_reset)
      begin
        o_mode <= `TIM_MODE_DEFAULT;
        o_stored_mode <= `TIM_MODE_DEFAULT;
        pending_mode <= `TIM_MODE_DEFAULT;
        esc_state <= `TIM_ESC_IDLE;
        o_send_greeting <= 1'b1;
      end
      else if (i_reset_cmd)
      begin
        o_mode <= o_stored_mode;
        esc_state <= `TIM_ESC_IDLE;
        o_send_greeting <= (o_stored_mode == `TIM_MODE_TERMINAL);
      end
      else if (esc_exit)
      begin
        o_mode <= `TIM_MODE_TERMINAL;
        o_stored_mode <= `TIM_MODE_TERMINAL;
        pending_mode <= `TIM_MODE_TERMINAL;
        o_send_greeting <= 1'b1;
      end
      else if (i_mode_select_wr)
      begin
        pending_mode <= i_interface_mode_select;
        o_stored_mode <= i_interface_mode_select;
        // Host mode is entered at once; raw mode only after a reset.
        if (i_interface_mode_select == `TIM_MODE_HOST)
          o_mode <= `TIM_MODE_HOST;
        else if (i_interface_mode_select == `TIM_MODE_TERMINAL && o_mode != `TIM_MODE_RAW)
          o_mode <= `TIM_MODE_TERMINAL;
      end
      // A terminal attaching while framed mode is still active gets the status message.
      if (connect_sync && !connect_prev && !i_hard_reset && !i_reset_cmd && !esc_exit)
      begin
        if (o_mode == `TIM_MODE_HOST)
          o_send_status <= 1'b1;
        else if (o_mode == `TIM_MODE_TERMINAL)
          o_send_greeting <= 1'b1;
      end
    end
  end

  // Received bytes are steered to the frame engine or the command parser;
  // the closing byte of an exit sequence is consumed here.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_frame_rx_valid <= 1'b0;
      o_frame_rx_data <= {DATA_WIDTH{1'b0}};
      o_cmd_rx_valid <= 1'b0;
      o_cmd_rx_data <= {DATA_WIDTH{1'b0}};
    end
    else
    begin
      o_frame_rx_valid <= i_host_rx_valid && (o_mode != `TIM_MODE_TERMINAL) && !esc_swallow;
      o_cmd_rx_valid <= i_host_rx_valid && (o_mode == `TIM_MODE_TERMINAL);
      if (i_host_rx_valid)
      begin
        o_frame_rx_data <= i_host_rx_data;
        o_cmd_rx_data <= i_host_rx_data;
      end
    end
  end

  // Flow control: CTS follows receive space and synchronised RTS; software flow only in terminal mode.
  // RTS from the host gates CTS here, after the two-flop synchroniser.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_host_cts <= 1'b0;
      o_soft_flow_enable <= 1'b0;
    end
    else
    begin
      o_host_cts <= i_rx_space && rts_sync;
      o_soft_flow_enable <= (o_mode == `TIM_MODE_TERMINAL);
    end
  end

  // Raw mode: unprocessed forwarding, format conversion, local channel timing.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_raw_forward <= 1'b0;
      o_raw_convert <= 1'b0;
      o_local_routing_enable <= 1'b1;
      o_channel_access_local <= 1'b1;
    end
    else
    begin
      o_raw_forward <= (o_mode == `TIM_MODE_RAW) && i_radio_frame_valid;
      o_raw_convert <= (o_mode == `TIM_MODE_RAW);
      o_local_routing_enable <= (o_mode != `TIM_MODE_RAW);
      o_channel_access_local <= 1'b1;
    end
  end

  // Auxiliary port routing; position input takes priority when both are set.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_aux_route <= `TIM_AUX_OFF;
      o_aux_rate <= {RATE_WIDTH{1'b0}};
    end
    else if (i_position_input_rate != {RATE_WIDTH{1'b0}})
    begin
      o_aux_route <= `TIM_AUX_POSITION;
      o_aux_rate <= i_position_input_rate;
    end
    else if (i_node_link_rate != {RATE_WIDTH{1'b0}})
    begin
      o_aux_route <= `TIM_AUX_NODE;
      o_aux_rate <= i_node_link_rate;
    end
    else
    begin
      o_aux_route <= `TIM_AUX_OFF;
      o_aux_rate <= {RATE_WIDTH{1'b0}};
    end
  end

  // Radio mode arbitration. Terminal mode: non-packet excludes packet use from the cycle after it goes active;
  // host mode lets packet run alongside one HF non-packet mode.
  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_nonpacket_active <= 1'b0;
      o_packet_grant <= 1'b0;
      o_vhf_remote_open <= 1'b1;
      o_morse_key_out <= 1'b0;
    end
    else
    begin
      o_nonpacket_active <= i_radio_nonpacket_req && (i_radio_nonpacket_port == `TIM_PORT_HF)
                            && (o_mode != `TIM_MODE_RAW);
      if (o_mode == `TIM_MODE_HOST)
        o_packet_grant <= i_packet_req;
      else if (o_mode == `TIM_MODE_TERMINAL)
        o_packet_grant <= i_packet_req && !o_nonpacket_active;
      else
        o_packet_grant <= 1'b0;
      o_vhf_remote_open <= 1'b1;
      o_morse_key_out <= i_morse_key && (i_morse_port == `TIM_PORT_HF);
    end
  end
endmodule // tim_host_if
`default_nettype wire

//--- sim/tim_host_if_props.sv
// Concurrent checks on the ports of the host interface mode controller.
`timescale 1ns/100ps
`default_nettype none
`include "tim_consts.vh"
module tim_host_if_props #(
  parameter DATA_WIDTH = 8,
  parameter RATE_WIDTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_host_rx_valid,
  input wire logic [DATA_WIDTH-1:0] i_host_rx_data,
  input wire logic i_host_rts,
  input wire logic i_reset_cmd,
  input wire logic i_hard_reset,
  input wire logic i_mode_select_wr,
  input wire logic [1:0] i_interface_mode_select,
  input wire logic [RATE_WIDTH-1:0] i_position_input_rate,
  input wire logic i_morse_port,
  input wire logic [1:0] o_mode,
  input wire logic [1:0] o_stored_mode,
  input wire logic o_host_cts,
  input wire logic o_send_greeting,
  input wire logic o_channel_access_local,
  input wire logic o_vhf_remote_open,
  input wire logic [1:0] o_aux_route,
  input wire logic o_morse_key_out
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Only bytes with no control strobe beside them: both resets outrank an escape exit, and a mode write can move the mode.
  wire calm = i_host_rx_valid && !i_reset_cmd && !i_hard_reset && !i_mode_select_wr;
  sequence s_fend;
    calm && i_host_rx_data == `TIM_BYTE_FRAME_END;
  endsequence
  sequence s_quit;
    calm && (i_host_rx_data == `TIM_BYTE_QUIT_LO || i_host_rx_data == `TIM_BYTE_QUIT_UP);
  endsequence
  sequence s_odd;
    calm && i_host_rx_data == 8'h58;
  endsequence
  sequence s_rawx;
    calm && i_host_rx_data == `TIM_BYTE_RAW_EXIT;
  endsequence
  AST_HOST_EXIT: assert property ((o_mode == `TIM_MODE_HOST) ##0 s_fend ##1 s_quit ##1 s_fend
    |=> o_mode == `TIM_MODE_TERMINAL && o_send_greeting) else $error("host exit missed");
  AST_BAD_ESC: assert property ((o_mode == `TIM_MODE_HOST) ##0 s_fend ##1 s_odd ##1 s_fend
    |=> o_mode == `TIM_MODE_HOST) else $error("bad escape changed mode");
  AST_RAW_EXIT: assert property ((o_mode == `TIM_MODE_RAW) ##0 s_fend ##1 s_rawx ##1 s_fend
    |=> o_mode == `TIM_MODE_TERMINAL) else $error("raw exit missed");
  AST_RAW_DEFER: assert property (i_mode_select_wr && i_interface_mode_select == `TIM_MODE_RAW && !i_reset_cmd
    && !i_hard_reset && o_mode != `TIM_MODE_RAW |=> o_mode != `TIM_MODE_RAW) else $error("raw not deferred");
  AST_RESET_CMD: assert property (i_reset_cmd && !i_hard_reset && !i_mode_select_wr
    |=> o_mode == $past(o_stored_mode)) else $error("reset did not apply stored mode");
  AST_HARD_RESET: assert property (i_hard_reset |=> o_mode == `TIM_MODE_DEFAULT
    && o_stored_mode == `TIM_MODE_DEFAULT) else $error("hard reset kept mode");
  AST_FIXED: assert property (o_channel_access_local && o_vhf_remote_open)
    else $error("channel access or vhf access dropped");
  AST_CTS: assert property ((!i_host_rts)[*4] |-> !o_host_cts) else $error("cts high with rts low");
  AST_MORSE: assert property (i_morse_port[*2] |-> !o_morse_key_out) else $error("morse on vhf");
  AST_AUX_POS: assert property ((i_position_input_rate != 0)[*2] |-> o_aux_route == `TIM_AUX_POSITION)
    else $error("aux not position input");
endmodule // tim_host_if_props
bind tim_host_if tim_host_if_props #(.DATA_WIDTH(DATA_WIDTH), .RATE_WIDTH(RATE_WIDTH)) tim_host_if_props_i (.*);
`default_nettype wire

//--- sim/tim_host_model.sv
// Behavioural host computer that sends bytes over the serial receive path.
`timescale 1ns/100ps
`default_nettype none
module tim_host_model (
  input wire logic i_clk,
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_rts
);
  // Idle data is the inverse of the last sent byte, so a late sample cannot match it by luck.
  initial
  begin
    o_valid = 1'h0;
    o_data = 8'h5a;
    o_rts = 1'h1;
  end
  // Whole 8-bit bytes back to back; pacing is by RTS/CTS only, never in-band flow bytes.
  task automatic send3(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] q[3];
    q = '{b0, b1, b2};
    foreach (q[i])
    begin
      @(posedge i_clk);
      o_valid <= 1'h1;
      o_data <= q[i];
    end
    @(posedge i_clk);
    o_valid <= 1'h0;
    o_data <= ~q[2];
  endtask
endmodule // tim_host_model
`default_nettype wire

//--- sim/tb_tim_host_if.sv
// Self-checking bench for the host interface mode controller.
`timescale 1ns/100ps
`default_nettype none
`include "tim_consts.vh"
module tb_tim_host_if;
  logic i_clk, i_rst_n, i_host_rx_valid, i_rx_space, i_host_rts, i_terminal_connect, i_reset_cmd, i_hard_reset;
  logic i_mode_select_wr, i_radio_frame_valid, i_radio_frame_port, i_radio_nonpacket_req, i_radio_nonpacket_port;
  logic i_packet_req, i_morse_key, i_morse_port, o_host_cts, o_soft_flow_enable, o_frame_rx_valid, o_cmd_rx_valid;
  logic o_send_greeting, o_send_status, o_raw_forward, o_raw_convert, o_local_routing_enable, o_channel_access_local;
  logic o_nonpacket_active, o_packet_grant, o_vhf_remote_open, o_morse_key_out;
  logic [7:0] i_host_rx_data, o_frame_rx_data, o_cmd_rx_data;
  logic [1:0] i_interface_mode_select, o_mode, o_stored_mode, o_aux_route;
  logic [15:0] i_position_input_rate, i_node_link_rate, o_aux_rate;
  int miscompares, comparisons, cnt[5];
  tim_host_if tim_host_if_i (.*);
  tim_host_model tim_host_model_i (.i_clk(i_clk), .o_valid(i_host_rx_valid), .o_data(i_host_rx_data), .o_rts(i_host_rts));
  initial
  begin
    i_clk = 1'h0;
    forever #50 i_clk = ~i_clk;
  end
  // Pulses last one cycle, so they are counted at every edge rather than sampled later.
  always @(posedge i_clk)
  begin
    cnt[0] += o_send_greeting === 1'h1;
    cnt[1] += o_send_status === 1'h1;
    cnt[2] += o_raw_forward === 1'h1;
    cnt[3] += o_frame_rx_valid === 1'h1;
    cnt[4] += o_cmd_rx_valid === 1'h1;
  end
  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Kind 0 writes the mode selection, 1 is the reset command, 2 the hard reset.
  task automatic cmd(input int kind, input logic [1:0] sel);
    @(posedge i_clk);
    i_mode_select_wr <= kind == 0;
    i_reset_cmd <= kind == 1;
    i_hard_reset <= kind == 2;
    i_interface_mode_select <= sel;
    @(posedge i_clk);
    {i_mode_select_wr, i_reset_cmd, i_hard_reset} <= 3'h0;
    repeat (2) @(negedge i_clk);
  endtask
  // The host holds off while CTS is low; a stuck CTS ends the run.
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    for (int n = 0; o_host_cts !== 1'h1; n++)
    begin
      if (n == 20)
      begin
        miscompares++;
        tally_and_finish;
      end
      @(negedge i_clk);
    end
    tim_host_model_i.send3(b0, b1, b2);
    repeat (2) @(negedge i_clk);
  endtask
  task automatic t_cts;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge i_clk);
      i_rx_space <= i != 1;
      tim_host_model_i.o_rts <= i != 0;
      repeat (4) @(negedge i_clk);
      check("cts", o_host_cts, i == 2);
    end
  endtask
  task automatic t_host;
    int g = cnt[0];
    int f = cnt[3];
    cmd(0, `TIM_MODE_HOST);
    check("soft_flow", o_soft_flow_enable, 1'h0);
    send(`TIM_BYTE_FRAME_END, 8'h58, `TIM_BYTE_FRAME_END);
    check("bad_escape", o_mode, `TIM_MODE_HOST);
    send(`TIM_BYTE_FRAME_END, `TIM_BYTE_QUIT_UP, `TIM_BYTE_FRAME_END);
    check("host_exit", o_mode, `TIM_MODE_TERMINAL);
    check("greeting", cnt[0] - g, 1);
    check("frames", cnt[3] - f, 5);
  endtask
  task automatic t_status;
    int g = cnt[0];
    int s = cnt[1];
    cmd(0, `TIM_MODE_HOST);
    @(posedge i_clk);
    i_terminal_connect <= 1'h1;
    repeat (8) @(negedge i_clk);
    // Status count weighs two, greeting count one, so both fit one compare.
    check("status", (cnt[1] - s) * 2 + (cnt[0] - g), 18'h2);
  endtask
  task automatic t_raw;
    int f = cnt[2];
    cmd(0, `TIM_MODE_RAW);
    check("raw_deferred", {o_mode, o_stored_mode}, {`TIM_MODE_HOST, `TIM_MODE_RAW});
    cmd(1, 2'h0);
    check("raw_active", o_mode, `TIM_MODE_RAW);
    cmd(1, 2'h0);
    check("raw_kept", o_mode, `TIM_MODE_RAW);
    check("raw_flags", {o_raw_convert, o_local_routing_enable, o_channel_access_local}, 3'h5);
    @(posedge i_clk);
    i_radio_frame_valid <= 1'h1;
    @(posedge i_clk);
    i_radio_frame_valid <= 1'h0;
    repeat (3) @(negedge i_clk);
    check("forward", cnt[2] - f, 1);
    send(`TIM_BYTE_FRAME_END, `TIM_BYTE_RAW_EXIT, `TIM_BYTE_FRAME_END);
    check("raw_exit", o_mode, `TIM_MODE_TERMINAL);
    cmd(2, 2'h0);
    check("hard_reset", o_stored_mode, `TIM_MODE_DEFAULT);
  endtask
  task automatic t_ports;
    int c = cnt[4];
    send(8'h41, 8'h42, 8'h43);
    check("cmd_bytes", cnt[4] - c, 3);
    check("cmd_data", o_cmd_rx_data, 8'h43);
    @(posedge i_clk);
    i_node_link_rate <= 16'h2580;
    {i_morse_key, i_radio_nonpacket_req, i_packet_req} <= 3'h7;
    repeat (3) @(negedge i_clk);
    check("node", {o_aux_route, o_aux_rate}, {`TIM_AUX_NODE, 16'h2580});
    check("morse_hf", o_morse_key_out, 1'h1);
    check("one_mode", o_nonpacket_active & o_packet_grant, 1'h0);
    @(posedge i_clk);
    i_position_input_rate <= 16'h12c0;
    i_morse_port <= `TIM_PORT_VHF;
    repeat (3) @(negedge i_clk);
    check("position", {o_aux_route, o_aux_rate}, {`TIM_AUX_POSITION, 16'h12c0});
    check("morse_vhf", o_morse_key_out, 1'h0);
  endtask
  // Reset first; scenarios then run in one sequence and the verdict closes the run.
  initial
  begin
    {i_rst_n, i_terminal_connect, i_reset_cmd, i_hard_reset, i_mode_select_wr, i_radio_frame_valid} = 6'h0;
    {i_radio_frame_port, i_radio_nonpacket_req, i_radio_nonpacket_port, i_packet_req, i_morse_key} = 5'h0;
    {i_morse_port, i_interface_mode_select, i_position_input_rate, i_node_link_rate} = 35'h0;
    i_rx_space = 1'h1;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'h1;
    repeat (2) @(negedge i_clk);
    t_cts;
    t_host;
    t_status;
    t_raw;
    t_ports;
    tally_and_finish;
  end
endmodule // tb_tim_host_if
`default_nettype wire
